// ===== shared/fbp_pkg.sv
// Constants and types for the flash block erase and protection unit
// Assumes a single clock domain and word-organised flash storage
package fbp_pkg;

    // ********************************************************
    // Geometry
    // ********************************************************
    localparam int FBP_FLASH_BYTES = 131072;          // Whole array
    localparam int FBP_BLOCK_BYTES = 1024;            // Erase unit
    localparam int FBP_REGION_BYTES = 2048;           // Protection unit
    localparam int FBP_WORD_BYTES = 4;
    localparam int FBP_NUM_WORDS = FBP_FLASH_BYTES / FBP_WORD_BYTES;
    localparam int FBP_NUM_BLOCKS = FBP_FLASH_BYTES / FBP_BLOCK_BYTES;
    localparam int FBP_NUM_REGIONS = FBP_FLASH_BYTES / FBP_REGION_BYTES;
    localparam int FBP_WORDS_PER_BLOCK = FBP_BLOCK_BYTES / FBP_WORD_BYTES;
    localparam int FBP_WIDX_W = 15;                   // Word index width
    localparam int FBP_BLK_W = 7;                     // Block index width
    localparam int FBP_REG_W = 6;                     // Region index width
    localparam int FBP_BLK_POS = 8;                   // Block field in word index
    localparam int FBP_REG_POS = 9;                   // Region field in word index

    // ********************************************************
    // Erased word and reset values
    // ********************************************************
    localparam logic [31:0] FBP_ERASED_WORD = 32'hFFFF_FFFF;
    localparam logic [1:0] FBP_PROT_RESET = 2'h0;

    // ********************************************************
    // Types
    // ********************************************************
    typedef enum logic [1:0] {
        FBP_PROT_OPEN = 2'h0,
        FBP_PROT_RDONLY = 2'h1,
        FBP_PROT_XONLY = 2'h2
    } fbp_prot_e;

    typedef enum logic [2:0] {
        FBP_OP_FETCH,
        FBP_OP_DREAD,
        FBP_OP_DBGREAD,
        FBP_OP_PROGRAM,
        FBP_OP_ERASE,
        FBP_OP_SETPROT
    } fbp_op_e;

endpackage : fbp_pkg

// ===== rtl/fbp_check.sv
// Access checker: decides whether one request may proceed
// Assumes protection code of the addressed region is already selected
`timescale 1ns/1ps
module fbp_check (
    input wire fbp_pkg::fbp_op_e i_op,      // Requested operation
    input wire logic [1:0] i_prot,          // Region protection code
    output logic o_allow                    // Request may proceed
);
    import fbp_pkg::*;

    // Permission matrix
    always_comb begin
        case (i_prot)
            FBP_PROT_RDONLY: o_allow = (i_op == FBP_OP_FETCH) || (i_op == FBP_OP_DREAD) ||
                                       (i_op == FBP_OP_DBGREAD) || (i_op == FBP_OP_SETPROT);
            FBP_PROT_XONLY: o_allow = (i_op == FBP_OP_FETCH) || (i_op == FBP_OP_SETPROT);
            default: o_allow = 1'b1;
        endcase
    end

endmodule : fbp_check

// ===== rtl/fbp_flash.sv
// Flash array model with block erase and per-region protection
// Assumes requesters are arbitrated outside and share i_clock and reset
// What this block does
// - 128 KB flash array, processor addressable
// - Independent 1 KB erase blocks
// - Erase sets every block bit to one
// - Independent protection per 2 KB region
// - Read-only regions refuse erase and program
// - Execute-only regions serve instruction fetch only
`timescale 1ns/1ps
module fbp_flash (
    input wire logic i_clock,                      // 40 MHz clock
    input wire logic i_rstn,                       // Async reset, active low
    input wire logic i_req,                        // Request strobe
    input wire fbp_pkg::fbp_op_e i_op,             // Operation
    input wire logic [16:0] i_addr,                // Byte address
    input wire logic [31:0] i_wdata,               // Program data
    input wire logic [1:0] i_prot,                 // Protection code for set
    output logic o_done,                           // Request accepted, pulse
    output logic o_err,                            // Request refused, pulse
    output logic [31:0] o_rdata,                   // Read data
    output logic [1:0] o_prot                      // Protection of last region
);
    import fbp_pkg::*;

    // ********************************************************
    // Operation decode
    // ********************************************************
    // Any of the three read kinds; only fetch survives execute-only
    function automatic logic is_read_op(input fbp_op_e op);
        return (op == FBP_OP_FETCH) || (op == FBP_OP_DREAD) || (op == FBP_OP_DBGREAD);
    endfunction : is_read_op

    // Operations that would change array contents
    function automatic logic is_write_op(input fbp_op_e op);
        return (op == FBP_OP_PROGRAM) || (op == FBP_OP_ERASE);
    endfunction : is_write_op

    // ********************************************************
    // State
    // ********************************************************
    // Synchroniser, answer pulses, held read data and held region code
    typedef struct packed {
        logic [1:0] sync;
        logic done;
        logic err;
        logic [31:0] rdata;
        logic [1:0] protq;
    } fbp_state_s;

    fbp_state_s st_r;
    fbp_state_s st_nxt;
    logic rst_n;
    logic [31:0] mem_r [FBP_NUM_WORDS];
    logic [1:0] prot_r [FBP_NUM_REGIONS];
    logic [FBP_WIDX_W-1:0] widx;
    logic [FBP_BLK_W-1:0] blk;
    logic [FBP_REG_W-1:0] rgn;
    logic allow;
    logic is_read;

    // ********************************************************
    // Address decode
    // ********************************************************
    // Word, erase block and protection region from the byte address;
    // the two low address bits are ignored, accesses are whole words
    assign widx = i_addr[16:2];
    assign blk = widx[FBP_WIDX_W-1:FBP_BLK_POS];
    assign rgn = widx[FBP_WIDX_W-1:FBP_REG_POS];
    // Second synchroniser stage gates requests; state and protection table reset on i_rstn directly
    assign rst_n = st_r.sync[1];
    assign is_read = is_read_op(i_op);

    // Permission lookup on the addressed region
    fbp_check u_check (
        .i_op(i_op),
        .i_prot(prot_r[rgn]),
        .o_allow(allow)
    );

    // ********************************************************
    // Control path
    // ********************************************************
    // Next state: reset release shifts in, each taken request gets one answer;
    // requests before the second synchroniser stage is high are dropped silently
    always_comb begin
        st_nxt = st_r;
        st_nxt.sync = {st_r.sync[0], 1'b1};
        st_nxt.done = 1'b0;
        st_nxt.err = 1'b0;
        if (i_req && rst_n) begin
            // Region code is reported for refused requests as well
            st_nxt.protq = prot_r[rgn];
            if (allow) begin
                st_nxt.done = 1'b1;
                st_nxt.rdata = is_read ? mem_r[widx] : 32'h0000_0000;
            end else begin
                st_nxt.err = 1'b1;
                st_nxt.rdata = 32'h0000_0000;      // Blocked reads return zero
            end
        end
    end

    // State register; reset clears the synchroniser so requests wait two edges
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ********************************************************
    // Storage
    // ********************************************************
    // Array updates. Programming can only clear bits, so a program is an AND
    // into the word; only an erase brings bits back to one, a whole block at once.
    // The array has no reset: its contents after power-up are unknown until erased.
    always_ff @(posedge i_clock) begin
        if (i_req && rst_n && allow) begin
            case (i_op)
                FBP_OP_PROGRAM: mem_r[widx] <= mem_r[widx] & i_wdata;
                FBP_OP_ERASE: begin
                    // Every word of the addressed block, and no other
                    for (int w = 0; w < FBP_WORDS_PER_BLOCK; w++) begin
                        mem_r[{blk, w[FBP_BLK_POS-1:0]}] <= FBP_ERASED_WORD;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Protection table, open after reset. SETPROT is never refused, so a
    // region can be loosened again; code 3 decodes as open in the checker
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int r = 0; r < FBP_NUM_REGIONS; r++) begin
                prot_r[r] <= FBP_PROT_RESET;
            end
        end else if (i_req && rst_n && (i_op == FBP_OP_SETPROT)) begin
            prot_r[rgn] <= i_prot;
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    // Every output is a field of the registered state
    assign o_done = st_r.done;
    assign o_err = st_r.err;
    assign o_rdata = st_r.rdata;
    assign o_prot = st_r.protq;

    // ********************************************************
    // Checks
    // ********************************************************
    // A read-only region must come through a program or erase unchanged
    ro_write_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
        (i_req && rst_n && prot_r[rgn] == FBP_PROT_RDONLY && is_write_op(i_op))
        |=> (o_err && !o_done && mem_r[$past(widx)] == $past(mem_r[widx])))
        else $error("read-only region modified");

    // An execute-only region refuses writes just as a read-only one does
    xo_write_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
        (i_req && rst_n && prot_r[rgn] == FBP_PROT_XONLY && is_write_op(i_op))
        |=> (o_err && !o_done && mem_r[$past(widx)] == $past(mem_r[widx])))
        else $error("execute-only region modified");

    // Read-only still serves every read kind with the stored word
    ro_read_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
        (i_req && rst_n && prot_r[rgn] == FBP_PROT_RDONLY && is_read_op(i_op))
        |=> (o_done && !o_err && o_rdata == $past(mem_r[widx])))
        else $error("read-only region read refused");

    // Data and debugger reads of execute-only code leak nothing
    xo_read_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
        (i_req && rst_n && prot_r[rgn] == FBP_PROT_XONLY && (i_op == FBP_OP_DREAD || i_op == FBP_OP_DBGREAD))
        |=> (o_err && o_rdata == 32'h0000_0000))
        else $error("execute-only data read served");

    // Instruction fetch is the one access execute-only code still serves
    xo_fetch_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
        (i_req && rst_n && prot_r[rgn] == FBP_PROT_XONLY && i_op == FBP_OP_FETCH) |=> (o_done && !o_err))
        else $error("execute-only fetch refused");

    // An accepted erase leaves the addressed word all ones
    erase_ones_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
        (i_req && rst_n && prot_r[rgn] == FBP_PROT_OPEN && i_op == FBP_OP_ERASE)
        |=> (mem_r[$past(widx)] == FBP_ERASED_WORD))
        else $error("erased word not all ones");

    // A protection update lands in the addressed region
    prot_set_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
        (i_req && rst_n && i_op == FBP_OP_SETPROT)
        |=> (prot_r[$past(rgn)] == $past(i_prot)))
        else $error("protection update lost");

    // The neighbouring region keeps its code; a decode slip here
    // would let one update change two regions
    prot_other_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
        (i_req && rst_n && i_op == FBP_OP_SETPROT)
        |=> (prot_r[$past(rgn) ^ 6'h01] == $past(prot_r[rgn ^ 6'h01])))
        else $error("neighbour region protection changed");

    // Every taken request is judged against its own region's code
    prot_state_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
        (i_req && rst_n) |=> (o_prot == $past(prot_r[rgn]) && (o_done != o_err)))
        else $error("access not checked against region");

    // No answer while the reset synchroniser still holds requests off
    reset_quiet_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
        (!rst_n)
        |=> (!o_done && !o_err))
        else $error("answer given before reset release");

    // Without a request there is no answer pulse
    idle_quiet_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
        (!i_req)
        |=> (!o_done && !o_err))
        else $error("answer without request");

endmodule : fbp_flash

// ===== dv/fbp_req_model.sv
// Requester model: fetch path, data path and debugger sharing one port
// Assumes it is called only after the reset synchroniser has released
`timescale 1ns/1ps
module fbp_req_model (
    input wire logic i_clock,           // Shared clock
    input wire logic i_done,            // Accept pulse
    input wire logic i_err,             // Refuse pulse
    input wire logic [31:0] i_rdata,    // Read data
    input wire logic [1:0] i_code,      // Region code seen
    output logic o_req,                 // Request strobe
    output fbp_pkg::fbp_op_e o_op,      // Operation
    output logic [16:0] o_addr,         // Byte address
    output logic [31:0] o_wdata,        // Program data
    output logic [1:0] o_prot           // Code for set
);
    import fbp_pkg::*;
    // Idle port at time zero
    initial begin
        o_req = 1'h0;
        o_op = FBP_OP_FETCH;
        o_addr = 17'h0;
        o_wdata = 32'h0;
        o_prot = 2'h0;
    end
    // One request for one edge; answer taken in the following cycle
    task automatic issue(input fbp_op_e op, input logic [16:0] ad, input logic [31:0] wd,
                         input logic [1:0] pr, output logic [31:0] res, output logic [31:0] rd);
        @(posedge i_clock);
        #1;
        o_req = 1'h1;
        o_op = op;
        o_addr = ad;
        o_wdata = wd;
        o_prot = pr;
        @(posedge i_clock);
        #1;
        o_req = 1'h0;
        o_wdata = ~wd;                  // Released data does not keep its value
        res = {28'h0, i_code, i_done, i_err};
        rd = i_rdata;
    endtask : issue
endmodule : fbp_req_model

// ===== dv/tb_top.sv
// Self-checking bench for the flash erase and protection unit
// Assumes the request model drives the single arbitrated port
`timescale 1ns/1ps
module tb_top;
    import fbp_pkg::*;
    logic clock, rstn, req, done, err;
    logic [16:0] addr;
    logic [31:0] wdata, rdata, res, rd;
    logic [1:0] prot, code;
    fbp_op_e op;
    int n_fail = 0;
    int n_tests = 0;
    int cycles = 0;
    // ********************************************************
    // Clock, instances and timeout
    // ********************************************************
    initial begin
        clock = 1'h0;
        forever #12.5 clock = ~clock;
    end
    fbp_flash fbp_flash_inst (.i_clock(clock), .i_rstn(rstn), .i_req(req), .i_op(op), .i_addr(addr),
        .i_wdata(wdata), .i_prot(prot), .o_done(done), .o_err(err), .o_rdata(rdata), .o_prot(code));
    fbp_req_model fbp_req_model_inst (.i_clock(clock), .i_done(done), .i_err(err), .i_rdata(rdata),
        .i_code(code), .o_req(req), .o_op(op), .o_addr(addr), .o_wdata(wdata), .o_prot(prot));
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            n_fail++;
            end_of_test();
        end
    end
    // ********************************************************
    // Shared tasks
    // ********************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Result word is code, done, err; data compared as well
    task automatic x(input fbp_op_e o, input logic [16:0] a, input logic [31:0] w, input logic [31:0] er,
                     input logic [31:0] ed);
        fbp_req_model_inst.issue(o, a, w, 2'h0, res, rd);
        chk(res, er);
        chk(rd, ed);
    endtask : x
    task automatic setp(input logic [16:0] a, input logic [1:0] p);
        fbp_req_model_inst.issue(FBP_OP_SETPROT, a, 32'h0, p, res, rd);
        chk(res & 32'h3, 32'h2);
    endtask : setp
    task automatic end_of_test;
        if (n_fail == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    // ********************************************************
    // Scenarios
    // ********************************************************
    task automatic t_erase;
        x(FBP_OP_ERASE, 17'h00400, 32'h0, 32'h2, 32'h0);
        x(FBP_OP_PROGRAM, 17'h00400, 32'h12345678, 32'h2, 32'h0);
        x(FBP_OP_ERASE, 17'h00000, 32'h0, 32'h2, 32'h0);
        x(FBP_OP_DREAD, 17'h003FC, 32'h0, 32'h2, 32'hFFFFFFFF);
        x(FBP_OP_DREAD, 17'h00400, 32'h0, 32'h2, 32'h12345678);
        x(FBP_OP_ERASE, 17'h1FC00, 32'h0, 32'h2, 32'h0);
        x(FBP_OP_PROGRAM, 17'h1FFFC, 32'hA5A50F0F, 32'h2, 32'h0);
        x(FBP_OP_FETCH, 17'h1FFFC, 32'h0, 32'h2, 32'hA5A50F0F);
    endtask : t_erase
    task automatic t_rdonly;
        x(FBP_OP_ERASE, 17'h00800, 32'h0, 32'h2, 32'h0);
        setp(17'h00000, 2'h1);
        x(FBP_OP_PROGRAM, 17'h00000, 32'h0, 32'h5, 32'h0);
        x(FBP_OP_ERASE, 17'h00400, 32'h0, 32'h5, 32'h0);
        x(FBP_OP_DREAD, 17'h00000, 32'h0, 32'h6, 32'hFFFFFFFF);
        x(FBP_OP_DBGREAD, 17'h00400, 32'h0, 32'h6, 32'h12345678);
        x(FBP_OP_PROGRAM, 17'h00800, 32'h0, 32'h2, 32'h0);
        x(FBP_OP_DREAD, 17'h00800, 32'h0, 32'h2, 32'h0);
    endtask : t_rdonly
    task automatic t_xonly;
        setp(17'h00000, 2'h2);
        x(FBP_OP_FETCH, 17'h00400, 32'h0, 32'hA, 32'h12345678);
        x(FBP_OP_DREAD, 17'h00400, 32'h0, 32'h9, 32'h0);
        x(FBP_OP_DBGREAD, 17'h00400, 32'h0, 32'h9, 32'h0);
        x(FBP_OP_PROGRAM, 17'h00000, 32'h0, 32'h9, 32'h0);
        setp(17'h00000, 2'h0);
        x(FBP_OP_ERASE, 17'h00400, 32'h0, 32'h2, 32'h0);
        x(FBP_OP_DREAD, 17'h00400, 32'h0, 32'h2, 32'hFFFFFFFF);
    endtask : t_xonly
    // Mid-run reset: outputs clear, table opens, array keeps its words; code 3 acts as open
    task automatic t_reset;
        setp(17'h00800, 2'h2);
        x(FBP_OP_DREAD, 17'h00800, 32'h0, 32'h9, 32'h0);
        rstn = 1'h0;
        @(posedge clock);
        #1;
        chk({28'h0, code, done, err}, 32'h0);
        chk(rdata, 32'h0);
        rstn = 1'h1;
        repeat (3) @(posedge clock);
        x(FBP_OP_DREAD, 17'h00800, 32'h0, 32'h2, 32'h0);
        setp(17'h00800, 2'h3);
        x(FBP_OP_PROGRAM, 17'h00800, 32'h0, 32'hE, 32'h0);
    endtask : t_reset
    // Reset, then the scenarios in order
    initial begin
        rstn = 1'h0;
        repeat (10) @(posedge clock);
        #1;
        rstn = 1'h1;
        repeat (3) @(posedge clock);
        t_erase();
        t_rdonly();
        t_xonly();
        t_reset();
        end_of_test();
    end
endmodule : tb_top
